// *** tucr_pkg.sv ***
// tucr_pkg: register map, field layout, reset values and encodings of the timer control registers
package tucr_pkg;

    // =========================================================================
    // register indices (byte address is four times the index)
    // =========================================================================
    localparam logic [7:0] IDX_SPLIT_MODE_CONTROL    = 8'h03;
    localparam logic [7:0] IDX_COUNTER_CONTROL_CLEAR = 8'h04;
    localparam logic [7:0] IDX_COUNTER_CONTROL_SET   = 8'h05;
    localparam logic [7:0] IDX_BUFFER_VALID_CLEAR    = 8'h06;
    localparam logic [7:0] IDX_BUFFER_VALID_SET      = 8'h07;
    localparam logic [7:0] IDX_EVENT_INPUT_CONTROL   = 8'h09;

    // =========================================================================
    // reset values
    // =========================================================================
    localparam logic [7:0] RST_SPLIT_MODE_CONTROL  = 8'h00;
    localparam logic [7:0] RST_COUNTER_CONTROL     = 8'h00;
    localparam logic [7:0] RST_BUFFER_VALID        = 8'h00;
    localparam logic [7:0] RST_EVENT_INPUT_CONTROL = 8'h00;

    // =========================================================================
    // field positions
    // =========================================================================
    localparam int SPLIT_MODE_ENABLE_BIT    = 0;
    localparam int DIR_BIT                  = 0;
    localparam int LOCK_UPDATE_BIT          = 1;
    localparam int CMD_LSB                  = 2;
    localparam int PERIOD_BUFFER_VALID_BIT  = 0;
    localparam int COMPARE0_BUFFER_VALID_BIT = 1;
    localparam int EVENT_INPUT_A_ENABLE_BIT = 0;
    localparam int EVENT_ACTION_A_LSB       = 1;
    localparam int EVENT_INPUT_B_ENABLE_BIT = 4;
    localparam int EVENT_ACTION_B_LSB       = 5;
    localparam int NUM_COMPARE              = 3;

    // =========================================================================
    // encodings
    // =========================================================================
    typedef enum logic [1:0] {
        CMD_NONE    = 2'h0,
        CMD_UPDATE  = 2'h1,
        CMD_RESTART = 2'h2,
        CMD_RESET   = 2'h3
    } tucr_cmd_t;

    typedef enum logic [2:0] {
        EVA_CNT_POSEDGE = 3'h0,
        EVA_CNT_ANYEDGE = 3'h1,
        EVA_CNT_HIGHLVL = 3'h2,
        EVA_UPDOWN      = 3'h3
    } tucr_eva_t;

    typedef enum logic [2:0] {
        EVB_NONE            = 3'h0,
        EVB_UPDOWN          = 3'h3,
        EVB_RESTART_POSEDGE = 3'h4,
        EVB_RESTART_ANYEDGE = 3'h5,
        EVB_RESTART_HIGHLVL = 3'h6
    } tucr_evb_t;

    // =========================================================================
    // state records
    // =========================================================================
    typedef struct packed {
        logic        meta;
        logic        sync;
    } tucr_sync_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        split;
        logic        lock_update;
        logic        dir;
        logic [3:0]  bv;
        logic [7:0]  event_input_control;
        logic        xfer;
        logic        restart;
        logic        hard_rst;
        logic        cnt_evt;
        logic        ev_a_prev;
        logic        ev_b_prev;
    } tucr_state_t;

endpackage

// *** tucr_rst_sync.sv ***
// tucr_rst_sync: two-stage release synchroniser for the asynchronous reset
`timescale 1ns/10ps
module tucr_rst_sync (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    output logic      rst_n_out
);

    tucr_pkg::tucr_sync_t q;
    tucr_pkg::tucr_sync_t d;

    // the first stage feeds only the second stage
    always_comb begin
        d      = q;
        d.meta = 1'b1;
        d.sync = q.meta;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rst_n_out = q.sync;

endmodule // tucr_rst_sync

// *** tucr_ctrl_regs.sv ***
// tucr_ctrl_regs: APB control/command registers and update tracking of a 16-bit timer
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module tucr_ctrl_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    input  wire logic              timer_enable_in,
    input  wire logic              update_cond_in,
    input  wire logic              period_buffer_wr_in,
    input  wire logic [2:0]        compare_buffer_wr_in,
    input  wire logic              hw_dir_load_in,
    input  wire logic              hw_dir_value_in,
    input  wire logic              count_tick_in,
    input  wire logic              event_a_in,
    input  wire logic              event_b_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    output logic                   split_mode_out,
    output logic                   lock_update_out,
    output logic                   count_dir_out,
    output logic [3:0]             buffer_valid_out,
    output logic                   buffer_transfer_out,
    output logic                   restart_out,
    output logic                   hard_reset_out,
    output logic                   count_event_out
);

    // =========================================================================
    // reset release
    // =========================================================================
    logic rst_n;

    tucr_rst_sync u_rst_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .rst_n_out  (rst_n)
    );

    tucr_pkg::tucr_state_t q;
    tucr_pkg::tucr_state_t d;

    // =========================================================================
    // APB decode
    // =========================================================================
    logic                setup_c;
    logic                wr_c;
    logic                mapped_c;
    logic [7:0]          idx_c;
    logic [7:0]          wd_c;
    logic [7:0]          rd_c;
    logic                wr_split_c;
    logic                wr_eclr_c;
    logic                wr_eset_c;
    logic                wr_fclr_c;
    logic                wr_fset_c;
    logic                wr_ev_c;
    logic                cmd_wr_c;
    tucr_pkg::tucr_cmd_t cmd_c;
    logic                force_upd_c;
    logic                force_rst_c;
    logic                hard_c;
    logic                xfer_c;
    logic [3:0]          bv_set_c;

    // index bits above bit 9 must be zero; ADDR_W is assumed to exceed 10
    assign idx_c    = paddr_in[9:2];
    assign mapped_c = (paddr_in[1:0] == 2'h0) && (paddr_in[ADDR_W-1:10] == '0) &&
                      ((idx_c == tucr_pkg::IDX_SPLIT_MODE_CONTROL) ||
                       (idx_c == tucr_pkg::IDX_COUNTER_CONTROL_CLEAR) ||
                       (idx_c == tucr_pkg::IDX_COUNTER_CONTROL_SET) ||
                       (idx_c == tucr_pkg::IDX_BUFFER_VALID_CLEAR) ||
                       (idx_c == tucr_pkg::IDX_BUFFER_VALID_SET) ||
                       (idx_c == tucr_pkg::IDX_EVENT_INPUT_CONTROL));
    assign setup_c  = psel_in && !penable_in;
    // writes land only at the access edge where pready is high
    assign wr_c     = psel_in && penable_in && q.pready && pwrite_in && pstrb_in[0] &&
                      !q.pslverr;
    assign wd_c     = pwdata_in[7:0];

    assign wr_split_c = wr_c && (idx_c == tucr_pkg::IDX_SPLIT_MODE_CONTROL);
    assign wr_eclr_c  = wr_c && (idx_c == tucr_pkg::IDX_COUNTER_CONTROL_CLEAR);
    assign wr_eset_c  = wr_c && (idx_c == tucr_pkg::IDX_COUNTER_CONTROL_SET);
    assign wr_fclr_c  = wr_c && (idx_c == tucr_pkg::IDX_BUFFER_VALID_CLEAR);
    assign wr_fset_c  = wr_c && (idx_c == tucr_pkg::IDX_BUFFER_VALID_SET);
    assign wr_ev_c    = wr_c && (idx_c == tucr_pkg::IDX_EVENT_INPUT_CONTROL);

    // =========================================================================
    // commands and update
    // =========================================================================
    assign cmd_wr_c    = wr_eclr_c || wr_eset_c;
    assign cmd_c       = tucr_pkg::tucr_cmd_t'(wd_c[tucr_pkg::CMD_LSB +: 2]);
    assign force_upd_c = cmd_wr_c && (cmd_c == tucr_pkg::CMD_UPDATE);
    assign force_rst_c = cmd_wr_c && (cmd_c == tucr_pkg::CMD_RESTART);
    assign hard_c      = cmd_wr_c && (cmd_c == tucr_pkg::CMD_RESET) && !timer_enable_in;
    // lock holds back hardware updates only
    assign xfer_c      = (update_cond_in && !q.lock_update) || force_upd_c;
    assign bv_set_c    = {compare_buffer_wr_in, period_buffer_wr_in};

    // =========================================================================
    // event inputs
    // =========================================================================
    logic                a_en_c;
    logic                b_en_c;
    tucr_pkg::tucr_eva_t a_act_c;
    tucr_pkg::tucr_evb_t b_act_c;
    logic                a_rise_c;
    logic                a_edge_c;
    logic                b_rise_c;
    logic                b_edge_c;
    logic                cnt_evt_c;
    logic                ev_restart_c;

    assign a_en_c   = q.event_input_control[tucr_pkg::EVENT_INPUT_A_ENABLE_BIT];
    assign b_en_c   = q.event_input_control[tucr_pkg::EVENT_INPUT_B_ENABLE_BIT];
    assign a_act_c  = tucr_pkg::tucr_eva_t'(q.event_input_control[tucr_pkg::EVENT_ACTION_A_LSB +: 3]);
    assign b_act_c  = tucr_pkg::tucr_evb_t'(q.event_input_control[tucr_pkg::EVENT_ACTION_B_LSB +: 3]);
    assign a_rise_c = event_a_in && !q.ev_a_prev;
    assign a_edge_c = event_a_in != q.ev_a_prev;
    assign b_rise_c = event_b_in && !q.ev_b_prev;
    assign b_edge_c = event_b_in != q.ev_b_prev;

    // reserved action codes do nothing
    assign cnt_evt_c = a_en_c && (
        ((a_act_c == tucr_pkg::EVA_CNT_POSEDGE) && a_rise_c) ||
        ((a_act_c == tucr_pkg::EVA_CNT_ANYEDGE) && a_edge_c) ||
        ((a_act_c == tucr_pkg::EVA_CNT_HIGHLVL) && count_tick_in && event_a_in) ||
        ((a_act_c == tucr_pkg::EVA_UPDOWN) && count_tick_in));
    assign ev_restart_c = b_en_c && (
        ((b_act_c == tucr_pkg::EVB_RESTART_POSEDGE) && b_rise_c) ||
        ((b_act_c == tucr_pkg::EVB_RESTART_ANYEDGE) && b_edge_c) ||
        ((b_act_c == tucr_pkg::EVB_RESTART_HIGHLVL) && event_b_in));

    // =========================================================================
    // read mux
    // =========================================================================
    always_comb begin
        case (idx_c)
            tucr_pkg::IDX_SPLIT_MODE_CONTROL: begin
                rd_c = {7'h00, q.split};
            end
            tucr_pkg::IDX_COUNTER_CONTROL_CLEAR,
            tucr_pkg::IDX_COUNTER_CONTROL_SET: begin
                rd_c = {4'h0, 2'h0, q.lock_update, q.dir};
            end
            tucr_pkg::IDX_BUFFER_VALID_CLEAR,
            tucr_pkg::IDX_BUFFER_VALID_SET: begin
                rd_c = {4'h0, q.bv};
            end
            tucr_pkg::IDX_EVENT_INPUT_CONTROL: begin
                rd_c = q.event_input_control;
            end
            default: begin
                rd_c = 8'h00;
            end
        endcase
    end

    // =========================================================================
    // next state
    // =========================================================================
    always_comb begin
        d           = q;
        // answer prepared in the setup cycle, so the access phase has no wait state
        d.pready    = setup_c;
        d.pslverr   = setup_c && !mapped_c;
        if (setup_c) begin
            d.prdata = (mapped_c && !pwrite_in) ? {24'h000000, rd_c} : 32'h00000000;
        end
        d.ev_a_prev = event_a_in;
        d.ev_b_prev = event_b_in;
        d.xfer      = xfer_c;
        d.restart   = force_rst_c || ev_restart_c;
        d.hard_rst  = hard_c;
        d.cnt_evt   = cnt_evt_c;

        if (wr_split_c) begin
            d.split = wd_c[tucr_pkg::SPLIT_MODE_ENABLE_BIT];
        end
        if (wr_ev_c) begin
            d.event_input_control = wd_c;
        end

        // hardware direction first; a software write in the same cycle overrides it
        if (hw_dir_load_in) begin
            d.dir = hw_dir_value_in;
        end
        if (count_tick_in) begin
            if (a_en_c && (a_act_c == tucr_pkg::EVA_UPDOWN)) begin
                d.dir = event_a_in;
            end else if (b_en_c && (b_act_c == tucr_pkg::EVB_UPDOWN)) begin
                d.dir = event_b_in;
            end
        end
        if (wr_eset_c) begin
            d.dir  = d.dir | wd_c[tucr_pkg::DIR_BIT];
            d.lock_update = q.lock_update | wd_c[tucr_pkg::LOCK_UPDATE_BIT];
        end
        if (wr_eclr_c) begin
            d.dir  = d.dir & ~wd_c[tucr_pkg::DIR_BIT];
            d.lock_update = q.lock_update & ~wd_c[tucr_pkg::LOCK_UPDATE_BIT];
        end

        // update clears first, then software and hardware sets win
        if (xfer_c) begin
            d.bv = 4'h0;
        end
        if (wr_fclr_c) begin
            d.bv = d.bv & ~wd_c[3:0];
        end
        if (wr_fset_c) begin
            d.bv = d.bv | wd_c[3:0];
        end
        d.bv = d.bv | bv_set_c;

        // hard reset returns the timer's own registers to their reset values;
        // a buffer strobe in the same cycle still sets its flag, so no write is lost
        if (hard_c) begin
            d.split  = tucr_pkg::RST_SPLIT_MODE_CONTROL[tucr_pkg::SPLIT_MODE_ENABLE_BIT];
            d.lock_update   = tucr_pkg::RST_COUNTER_CONTROL[tucr_pkg::LOCK_UPDATE_BIT];
            d.dir    = tucr_pkg::RST_COUNTER_CONTROL[tucr_pkg::DIR_BIT];
            d.bv     = tucr_pkg::RST_BUFFER_VALID[3:0] | bv_set_c;
            d.event_input_control = tucr_pkg::RST_EVENT_INPUT_CONTROL;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // =========================================================================
    // outputs
    // =========================================================================
    assign prdata_out          = q.prdata;
    assign pready_out          = q.pready;
    assign pslverr_out         = q.pslverr;
    assign split_mode_out      = q.split;
    assign lock_update_out     = q.lock_update;
    assign count_dir_out       = q.dir;
    assign buffer_valid_out    = q.bv;
    assign buffer_transfer_out = q.xfer;
    assign restart_out         = q.restart;
    assign hard_reset_out      = q.hard_rst;
    assign count_event_out     = q.cnt_evt;

    // =========================================================================
    // assertions
    // =========================================================================
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    split_write_a: assert property (wr_split_c |=> split_mode_out == $past(wd_c[0]))
        else $error("split enable did not follow the write");
    clear_lock_a: assert property (wr_eclr_c && cmd_c != tucr_pkg::CMD_RESET |=>
        lock_update_out == ($past(lock_update_out) && !$past(wd_c[1])))
        else $error("clear write changed lock wrongly");
    set_lock_a: assert property (wr_eset_c && cmd_c != tucr_pkg::CMD_RESET |=>
        lock_update_out == ($past(lock_update_out) || $past(wd_c[1])))
        else $error("set write changed lock wrongly");
    force_update_a: assert property (force_upd_c |=> buffer_transfer_out)
        else $error("update command gave no transfer");
    force_restart_a: assert property (force_rst_c |=>
        restart_out)
        else $error("restart command gave no restart");
    hard_reset_a: assert property (cmd_wr_c && cmd_c == tucr_pkg::CMD_RESET |=>
        hard_reset_out == !$past(timer_enable_in))
        else $error("hard reset ignored the enable");
    hard_clear_a: assert property (hard_c |=> !lock_update_out && !split_mode_out &&
        count_dir_out == 1'b0 && buffer_valid_out == $past(bv_set_c))
        else $error("hard reset left state behind");
    cmd_reads_zero_a: assert property (pready_out && !pslverr_out && !pwrite_in &&
        (idx_c == tucr_pkg::IDX_COUNTER_CONTROL_SET ||
         idx_c == tucr_pkg::IDX_COUNTER_CONTROL_CLEAR) |-> prdata_out[3:2] == 2'h0)
        else $error("command field read nonzero");
    open_update_a: assert property (update_cond_in && !lock_update_out |=>
        buffer_transfer_out)
        else $error("unlocked update did not transfer");
    locked_update_a: assert property (update_cond_in && lock_update_out &&
        !force_upd_c |=> !buffer_transfer_out)
        else $error("locked update transferred");
    lock_override_a: assert property (lock_update_out && force_upd_c |=>
        buffer_transfer_out && buffer_valid_out == $past(bv_set_c))
        else $error("lock blocked the update command");
    hw_dir_a: assert property (hw_dir_load_in && !count_tick_in && !cmd_wr_c |=>
        count_dir_out == $past(hw_dir_value_in))
        else $error("direction ignored hardware");
    dir_hold_a: assert property (!hw_dir_load_in && !count_tick_in && !cmd_wr_c |=>
        $stable(count_dir_out))
        else $error("direction changed without cause");
    cmp_valid_a: assert property (compare_buffer_wr_in[0] && !hard_c |=>
        buffer_valid_out[tucr_pkg::COMPARE0_BUFFER_VALID_BIT])
        else $error("compare 0 valid not set");
    per_valid_a: assert property (period_buffer_wr_in && !hard_c |=>
        buffer_valid_out[tucr_pkg::PERIOD_BUFFER_VALID_BIT])
        else $error("period valid not set");
    update_clear_a: assert property (xfer_c && bv_set_c == 4'h0 && !wr_fset_c |=>
        buffer_valid_out == 4'h0)
        else $error("update left a valid flag set");
    event_a_off_a: assert property (!a_en_c |=> !count_event_out)
        else $error("disabled event A counted");
    event_a_edge_a: assert property (a_en_c && a_act_c == tucr_pkg::EVA_CNT_POSEDGE &&
        !event_a_in ##1 event_a_in && $stable(q.event_input_control) |=> count_event_out)
        else $error("event A edge not counted");
    event_b_restart_a: assert property (b_en_c &&
        b_act_c == tucr_pkg::EVB_RESTART_HIGHLVL && event_b_in |=> restart_out)
        else $error("event B level gave no restart");

    cover_locked_update_c: cover property (lock_update_out && update_cond_in ##1
        force_upd_c ##1 buffer_transfer_out);
    cover_write_in_update_c: cover property (period_buffer_wr_in && xfer_c);
    cover_hard_reset_c: cover property (hard_c ##1 hard_reset_out);
    cover_unmapped_c: cover property (pready_out && pslverr_out);

endmodule // tucr_ctrl_regs

// *** tucr_ctrl_regs_test.sv ***
// tucr_ctrl_regs_test: self-checking bench for the timer control registers
`timescale 1ns/10ps
module tucr_ctrl_regs_test;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd = 32'h0, rdat, prdata;
    logic        serr, pready, pslverr, split, lock, dir, xf, rs, hr, ce;
    logic        ten = 1'b0, upd = 1'b0, pbw = 1'b0, tick = 1'b0, eva = 1'b0, evb = 1'b0;
    logic        hdl = 1'b0, hdv = 1'b0;
    logic [2:0]  cbw = 3'h0;
    logic [3:0]  bv;
    logic [11:0] map [6] = '{12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h024};
    int          err_total = 0, checks_done = 0, cyc = 0, nx = 0, nr = 0, nh = 0, nc = 0;
    tucr_ctrl_regs tucr_ctrl_regs_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd),
        .pstrb_in(4'hf), .timer_enable_in(ten), .update_cond_in(upd),
        .period_buffer_wr_in(pbw), .compare_buffer_wr_in(cbw), .hw_dir_load_in(hdl),
        .hw_dir_value_in(hdv), .count_tick_in(tick), .event_a_in(eva), .event_b_in(evb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .split_mode_out(split), .lock_update_out(lock), .count_dir_out(dir),
        .buffer_valid_out(bv), .buffer_transfer_out(xf), .restart_out(rs),
        .hard_reset_out(hr), .count_event_out(ce));
    // =========================================================================
    // clock, pulse counters and hang guard
    // =========================================================================
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (xf === 1'b1) nx++;
        if (rs === 1'b1) nr++;
        if (hr === 1'b1) nh++;
        if (ce === 1'b1) nc++;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end
    task automatic results();
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // =========================================================================
    // apb master: request held until pready is sampled high
    // =========================================================================
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d; pen <= 1'b0;
        @(posedge clk) pen <= 1'b1;
        // no local timeout; if pready never comes, only the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk("prdata", e, rdat);
    endtask
    // core strobes last one cycle; two more edges let the outputs settle
    task automatic drv(input logic u, input logic p, input logic [2:0] c, input logic t);
        upd <= u; pbw <= p; cbw <= c; tick <= t;
        @(posedge clk) upd <= 1'b0;
        pbw <= 1'b0; cbw <= 3'h0; tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (map[i]) rd(map[i], 32'h0);
        xfer(1'b1, 12'h014, 32'h03);
        chk("dir", 1, dir);
        chk("lock", 1, lock);
        rd(12'h014, 32'h03);
        rd(12'h010, 32'h03);
        xfer(1'b1, 12'h010, 32'h01);
        rd(12'h014, 32'h02);
        chk("dir", 0, dir);
        xfer(1'b1, 12'h00c, 32'h01);
        chk("split", 1, split);
        xfer(1'b1, 12'h040, 32'hff);
        chk("pslverr", 1, serr);
        drv(1'b0, 1'b1, 3'h7, 1'b0);
        chk("valid", 4'hf, bv);
        drv(1'b1, 1'b0, 3'h0, 1'b0);
        chk("xfer", 0, nx);
        chk("valid", 4'hf, bv);
        xfer(1'b1, 12'h014, 32'h04);
        chk("xfer", 1, nx);
        chk("valid", 4'h0, bv);
        xfer(1'b1, 12'h010, 32'h02);
        drv(1'b0, 1'b0, 3'h1, 1'b0);
        drv(1'b1, 1'b1, 3'h0, 1'b0);
        chk("xfer", 2, nx);
        chk("valid", 4'h1, bv);
        xfer(1'b1, 12'h01c, 32'h0c);
        xfer(1'b1, 12'h018, 32'h05);
        rd(12'h01c, 32'h08);
        rd(12'h018, 32'h08);
        ten <= 1'b1;
        xfer(1'b1, 12'h014, 32'h0c);
        chk("hard reset", 0, nh);
        xfer(1'b1, 12'h010, 32'h08);
        chk("restart", 1, nr);
        rd(12'h010, 32'h00);
        ten <= 1'b0;
        xfer(1'b1, 12'h010, 32'h0c);
        chk("hard reset", 1, nh);
        chk("split", 0, split);
        xfer(1'b1, 12'h024, 32'h07);
        eva <= 1'b1;
        drv(1'b0, 1'b0, 3'h0, 1'b1);
        chk("dir", 1, dir);
        chk("count event", 1, nc);
        hdl <= 1'b1;
        hdv <= 1'b0;
        @(posedge clk) hdl <= 1'b0;
        repeat (2) @(posedge clk);
        chk("dir", 0, dir);
        xfer(1'b1, 12'h024, 32'h01);
        eva <= 1'b0;
        drv(1'b0, 1'b0, 3'h0, 1'b0);
        eva <= 1'b1;
        drv(1'b0, 1'b0, 3'h0, 1'b0);
        chk("count event", 2, nc);
        xfer(1'b1, 12'h024, 32'h80);
        evb <= 1'b1;
        drv(1'b0, 1'b0, 3'h0, 1'b0);
        chk("restart", 1, nr);
        evb <= 1'b0;
        xfer(1'b1, 12'h024, 32'h90);
        evb <= 1'b1;
        drv(1'b0, 1'b0, 3'h0, 1'b0);
        chk("restart", 2, nr);
        results();
    end
endmodule // tucr_ctrl_regs_test
